// ---- verilog/dcl_defs.vh ----
// Constants for the daisy-chain single-wire link node
`ifndef DCL_DEFS_VH
`define DCL_DEFS_VH
// Header word fields
`define DCL_HDR_GLOBAL      0
`define DCL_HDR_READ        1
`define DCL_HDR_COMMAND     2
`define DCL_HDR_FIELD_LSB   3
`define DCL_HDR_FIELD_MSB   7
// Command codes
`define DCL_CMD_ADDR_INIT   8'h95
`define DCL_CMD_LAST_POLL   8'h57
`define DCL_CMD_SOFT_RESET  8'h5D
`define DCL_CMD_ALERT_CLR1  8'hB5
`define DCL_CMD_ALERT_CLR2  8'h75
// Calibration: five falling edges of 55h span eight bit times
`define DCL_CAL_FALLS       3'h4
`define DCL_CAL_SHIFT       3
// Timing: clock rate and documented times
`define DCL_CLK_HZ          10000000
`define DCL_INIT_GAP_MS     7
`define DCL_INIT_TIMEOUT_MS 1000
`define DCL_OP_TIMEOUT_MS   35
`define DCL_CYC_PER_MS      (`DCL_CLK_HZ / 1000)
// Register file reset value after reset or soft reset
`define DCL_REG_DEFAULT     16'h0000
// Register bus offsets and fields
`define DCL_OFS_STATUS      8'h00
`define DCL_OFS_CONTROL     8'h04
`define DCL_OFS_REGS        8'h40
`define DCL_CTRL_RESPOND    0
`define DCL_CTRL_RESET      1'h1
`define DCL_RESP_OKAY       2'h0
`define DCL_RESP_SLVERR     2'h2
`endif

// ---- verilog/dcl_link.v ----
// Daisy-chain single-wire link node with AXI4-Lite register access
`timescale 1ns/1ns
`include "dcl_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Byte receiver at a measured bit period
module dcl_rx (
  input  wire        mclk,    // System clock
  input  wire        reset_n, // Async reset, active low
  input  wire        en,      // Receiver enabled
  input  wire        line,    // Synchronised line level
  input  wire [15:0] period,  // Clocks per bit
  output reg         vld,     // One-cycle pulse, byte received
  output reg  [7:0]  data     // Received byte
);
  reg        armed;
  reg        busy;
  reg [15:0] cnt;
  reg [3:0]  bits;

  // Start-bit search, mid-bit sampling, stop check
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      armed <= 1'b0;
      busy  <= 1'b0;
      cnt   <= 16'h0000;
      bits  <= 4'h0;
      vld   <= 1'b0;
      data  <= 8'h00;
    end else begin
      vld <= 1'b0;
      if (!en) begin
        armed <= 1'b0;
        busy  <= 1'b0;
      end else if (!busy) begin
        if (line)
          armed <= 1'b1;
        else if (armed) begin
          busy  <= 1'b1;
          armed <= 1'b0;
          cnt   <= {1'b0, period[15:1]};
          bits  <= 4'h0;
        end
      end else if (cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end else begin
        cnt  <= period - 16'h0001;
        bits <= bits + 4'h1;
        if (bits == 4'h0 && line)
          busy <= 1'b0;
        else if (bits == 4'h9) begin
          busy <= 1'b0;
          vld  <= line;
        end else if (bits != 4'h0)
          data <= {line, data[7:1]};
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
module dcl_link #(
  parameter INIT_GAP_CYC     = `DCL_INIT_GAP_MS * `DCL_CYC_PER_MS,
  parameter INIT_TIMEOUT_CYC = `DCL_INIT_TIMEOUT_MS * `DCL_CYC_PER_MS,
  parameter OP_TIMEOUT_CYC   = `DCL_OP_TIMEOUT_MS * `DCL_CYC_PER_MS
) (
  input  wire        mclk,        // System clock, 10 MHz
  input  wire        reset_n,     // Async reset, active low
  input  wire        up_in,       // Upstream port, line level in
  output reg         up_out,      // Upstream port, line level out
  output reg         up_oe_n,     // Upstream port drive enable, low drives
  input  wire        dn_in,       // Downstream port, line level in
  output reg         dn_out,      // Downstream port, line level out
  output reg         dn_oe_n,     // Downstream port drive enable, low drives
  input  wire [31:0] s_axi_awaddr,  // Write address
  input  wire        s_axi_awvalid, // Write address valid
  output reg         s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire        s_axi_wvalid,  // Write data valid
  output reg         s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [31:0] s_axi_araddr,  // Read address
  input  wire        s_axi_arvalid, // Read address valid
  output reg         s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read data valid
  input  wire        s_axi_rready   // Read data ready
);
  localparam [12:0] S_IDLE = 13'h0001, S_CAL  = 13'h0002, S_HDR  = 13'h0004;
  localparam [12:0] S_PTR  = 13'h0008, S_WDAT = 13'h0010, S_RWAIT = 13'h0020;
  localparam [12:0] S_POLL = 13'h0040, S_TXO  = 13'h0080, S_IASN = 13'h0100;
  localparam [12:0] S_IPRG = 13'h0200, S_ITXU = 13'h0400, S_ITXD = 13'h0800;
  localparam [12:0] S_IRLY = 13'h1000;

  reg [12:0] st;
  reg        up_s1, up_s2, up_s3, dn_s1, dn_s2;
  reg [19:0] cal_cnt;
  reg [2:0]  falls;
  reg [15:0] period;
  reg [7:0]  hdr;
  reg [3:0]  ptr;
  reg [7:0]  wlo;
  reg        wbyte;
  reg [5:0]  need;
  reg [5:0]  rcnt;
  reg [4:0]  pos;
  reg        is_last;
  reg [23:0] wd;
  reg [23:0] gap;
  reg [10:0] tx_sh;
  reg        tx_busy, tx_up, tx_pend;
  reg [7:0]  tx_hold;
  reg [15:0] tx_cnt;
  reg [3:0]  tx_bits;
  reg [15:0] regs [0:15];
  reg        resp_en;
  reg        aw_hold, w_hold, sw_we;
  reg [7:0]  aw_ofs, ar_ofs;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        aw_bad;
  integer    i;

  wire       up_vld, dn_vld;
  wire [7:0] up_data, dn_data;
  wire       glob  = hdr[`DCL_HDR_GLOBAL];
  wire       rd    = hdr[`DCL_HDR_READ];
  wire [4:0] fld   = hdr[`DCL_HDR_FIELD_MSB:`DCL_HDR_FIELD_LSB];
  wire       up_rx_en = |(st & (S_HDR | S_PTR | S_WDAT | S_IASN));
  wire       dn_rx_en = |(st & (S_RWAIT | S_POLL | S_IRLY));

  // Frame with one idle bit ahead, start, data LSB first, stop
  function [10:0] dcl_frame;
    input [7:0] b;
    dcl_frame = {1'b1, b, 1'b0, 1'b1};
  endfunction

  // global or single selection
  // Selection: global covers positions up to field, individual exact
  function dcl_sel;
    input       g;
    input [4:0] p;
    input [4:0] f;
    dcl_sel = g ? (p <= f) : (p == f);
  endfunction

  dcl_rx u_up_rx (.mclk(mclk), .reset_n(reset_n), .en(up_rx_en), .line(up_s2),
                  .period(period), .vld(up_vld), .data(up_data));
  dcl_rx u_dn_rx (.mclk(mclk), .reset_n(reset_n), .en(dn_rx_en), .line(dn_s2),
                  .period(period), .vld(dn_vld), .data(dn_data));

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, idle high
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      up_s1 <= 1'b1;
      up_s2 <= 1'b1;
      up_s3 <= 1'b1;
      dn_s1 <= 1'b1;
      dn_s2 <= 1'b1;
    end else begin
      up_s1 <= up_in;
      up_s2 <= up_s1;
      up_s3 <= up_s2;
      dn_s1 <= dn_in;
      dn_s2 <= dn_s1;
    end
  end

  // Pin drivers: own transmitter first, otherwise relay
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      up_out  <= 1'b1;
      up_oe_n <= 1'b1;
      dn_out  <= 1'b1;
      dn_oe_n <= 1'b1;
    end else begin
      up_out  <= (tx_busy && tx_up) ? tx_sh[0] : dn_s2;
      up_oe_n <= ~((tx_busy && tx_up) || |(st & (S_RWAIT | S_POLL | S_IRLY)));
      dn_out  <= (tx_busy && !tx_up) ? tx_sh[0] : up_s2;
      dn_oe_n <= ~((tx_busy && !tx_up) ||
                   |(st & (S_IDLE | S_CAL | S_HDR | S_PTR | S_WDAT)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine, transmitter and register file
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= S_IDLE;
      cal_cnt <= 20'h00000;
      falls <= 3'h0;
      period <= 16'h0001;
      hdr <= 8'h00;
      ptr <= 4'h0;
      wlo <= 8'h00;
      wbyte <= 1'b0;
      need <= 6'h00;
      rcnt <= 6'h00;
      pos <= 5'h00;
      is_last <= 1'b0;
      wd <= 24'h000000;
      gap <= 24'h000000;
      tx_sh <= 11'h7FF;
      tx_busy <= 1'b0;
      tx_up <= 1'b1;
      tx_pend <= 1'b0;
      tx_hold <= 8'h00;
      tx_cnt <= 16'h0000;
      tx_bits <= 4'h0;
      for (i = 0; i < 16; i = i + 1)
        regs[i] <= `DCL_REG_DEFAULT;
    end else begin
      // bit serialiser, second byte follows the first
      if (tx_busy) begin
        if (tx_cnt != 16'h0000)
          tx_cnt <= tx_cnt - 16'h0001;
        else begin
          tx_cnt  <= period - 16'h0001;
          tx_sh   <= {1'b1, tx_sh[10:1]};
          tx_bits <= tx_bits + 4'h1;
          if (tx_bits == 4'hA) begin
            tx_bits <= 4'h0;
            tx_busy <= tx_pend;
            tx_pend <= 1'b0;
            if (tx_pend)
              tx_sh <= dcl_frame(tx_hold);
          end
        end
      end
      // Software access to the register file
      if (sw_we)
        regs[aw_ofs[5:2]] <= {w_strb[1] ? w_data[15:8] : regs[aw_ofs[5:2]][15:8],
                              w_strb[0] ? w_data[7:0] : regs[aw_ofs[5:2]][7:0]};
      // Watchdog restarts on traffic
      if (st == S_IDLE || up_vld || dn_vld)
        wd <= 24'h000000;
      else
        wd <= wd + 24'h000001;
      case (st)
        S_IDLE: begin
          // only a host start bit opens an operation
          if (!up_s2 && up_s3) begin
            st <= S_CAL;
            // The detecting cycle already counts, so eight bits give 8 x period
            cal_cnt <= 20'h00001;
            falls <= 3'h0;
          end
        end
        S_CAL: begin
          cal_cnt <= cal_cnt + 20'h00001;
          if (!up_s2 && up_s3) begin
            falls <= falls + 3'h1;
            if (falls == `DCL_CAL_FALLS - 3'h1) begin
              period <= cal_cnt[15 + `DCL_CAL_SHIFT:`DCL_CAL_SHIFT];
              st <= (cal_cnt[19:`DCL_CAL_SHIFT] == 17'h00000) ? S_IDLE : S_HDR;
            end
          end
          if (cal_cnt == 20'hFFFFF)
            st <= S_IDLE;
        end
        S_HDR: if (up_vld) begin
          hdr <= up_data;
          if (up_data[`DCL_HDR_COMMAND]) begin
            case (up_data)
              `DCL_CMD_ADDR_INIT: st <= S_IASN;
              `DCL_CMD_LAST_POLL: begin
                if (is_last && resp_en) begin
                  tx_sh <= dcl_frame({pos, 3'h0});
                  tx_busy <= 1'b1;
                  tx_up <= 1'b1;
                  tx_bits <= 4'h0;
                  tx_cnt <= period - 16'h0001;
                  st <= S_TXO;
                end else
                  st <= S_POLL; // never answer, only relay
              end
              `DCL_CMD_SOFT_RESET: begin
                for (i = 0; i < 16; i = i + 1)
                  regs[i] <= `DCL_REG_DEFAULT;
                st <= S_IDLE;
              end
              default: st <= S_IDLE;
            endcase
          end else
            st <= S_PTR; // pointer only for address ops
        end
        S_PTR: if (up_vld) begin
          ptr <= up_data[3:0];
          wbyte <= 1'b0;
          rcnt <= 6'h00;
          if (!rd)
            st <= S_WDAT;
          else if (pos == fld && resp_en) begin
            tx_sh <= dcl_frame(regs[up_data[3:0]][7:0]);
            tx_hold <= regs[up_data[3:0]][15:8];
            tx_pend <= 1'b1;
            tx_busy <= 1'b1;
            tx_up <= 1'b1;
            tx_bits <= 4'h0;
            tx_cnt <= period - 16'h0001;
            st <= S_TXO;
          end else if (pos < fld) begin
            need <= glob ? ({1'b0, fld - pos} << 1) : 6'h02;
            st <= S_RWAIT;
          end else
            st <= S_IDLE; // out of range, relay only
        end
        S_WDAT: if (up_vld) begin
          wbyte <= 1'b1;
          wlo <= up_data;
          if (wbyte) begin
            st <= S_IDLE;
            if (dcl_sel(glob, pos, fld) && resp_en)
              regs[ptr] <= {up_data, wlo}; // store data
          end
        end
        S_RWAIT: if (dn_vld) begin
          rcnt <= rcnt + 6'h01;
          if (rcnt + 6'h01 == need) begin
            if (glob && resp_en) begin
              tx_sh <= dcl_frame(regs[ptr][7:0]);
              tx_hold <= regs[ptr][15:8];
              tx_pend <= 1'b1;
              tx_busy <= 1'b1;
              tx_up <= 1'b1;
              tx_bits <= 4'h0;
              tx_cnt <= period - 16'h0001;
              st <= S_TXO;
            end else
              st <= S_IDLE;
          end
        end
        S_POLL: if (dn_vld)
          st <= S_IDLE;
        S_TXO: if (!tx_busy)
          st <= S_IDLE;
        S_IASN: if (up_vld) begin
          pos <= up_data[`DCL_HDR_FIELD_MSB:`DCL_HDR_FIELD_LSB];
          gap <= 24'h000000;
          st <= S_IPRG;
        end
        S_IPRG: begin
          gap <= gap + 24'h000001;
          if (gap == INIT_GAP_CYC - 1) begin
            tx_sh <= dcl_frame({pos, 3'h0});
            tx_busy <= 1'b1;
            tx_up <= 1'b1;
            tx_bits <= 4'h0;
            tx_cnt <= period - 16'h0001;
            st <= S_ITXU;
          end
        end
        S_ITXU: if (!tx_busy) begin
          tx_sh <= dcl_frame({pos + 5'h01, 3'h0});
          tx_busy <= 1'b1;
          tx_up <= 1'b0;
          tx_bits <= 4'h0;
          tx_cnt <= period - 16'h0001;
          st <= S_ITXD;
        end
        S_ITXD: if (!tx_busy) begin
          gap <= 24'h000000;
          st <= S_IRLY;
        end
        S_IRLY: begin
          gap <= gap + 24'h000001;
          if (dn_vld) begin
            gap <= 24'h000000;
            is_last <= 1'b0;
          end else if (gap == 2 * INIT_GAP_CYC) begin
            // last flag fixed at init only
            is_last <= (rcnt == 6'h00) ? 1'b1 : is_last;
            st <= S_IDLE;
          end
          if (dn_vld)
            rcnt <= 6'h01;
        end
        default: st <= S_IDLE;
      endcase
      // init stall releases after one second
      if (|(st & (S_IASN | S_IPRG | S_ITXU | S_ITXD | S_IRLY)) &&
          wd == INIT_TIMEOUT_CYC - 1)
        st <= S_IDLE;
      // other operations give up after 35 ms
      if (|(st & (S_CAL | S_HDR | S_PTR | S_WDAT | S_RWAIT | S_POLL)) &&
          wd == OP_TIMEOUT_CYC - 1)
        st <= S_IDLE;
      if (st == S_ITXD)
        rcnt <= 6'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DCL_RESP_OKAY;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_ofs  <= 8'h00;
      aw_bad  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      sw_we   <= 1'b0;
      resp_en <= `DCL_CTRL_RESET;
    end else begin
      sw_we <= 1'b0;
      s_axi_awready <= !aw_hold && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_ofs  <= s_axi_awaddr[7:0];
        aw_bad  <= (s_axi_awaddr[31:8] != 24'h000000) ||
                   !(s_axi_awaddr[7:0] == `DCL_OFS_CONTROL ||
                     s_axi_awaddr[7:6] == 2'h1);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Both halves held: commit and answer
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_bad ? `DCL_RESP_SLVERR : `DCL_RESP_OKAY;
        if (!aw_bad && aw_ofs == `DCL_OFS_CONTROL && w_strb[0])
          resp_en <= w_data[`DCL_CTRL_RESPOND];
        sw_we <= !aw_bad && aw_ofs[7:6] == 2'h1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DCL_RESP_OKAY;
      ar_ofs <= 8'h00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        ar_ofs <= s_axi_araddr[7:0];
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DCL_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr[31:8] != 24'h000000)
          s_axi_rresp <= `DCL_RESP_SLVERR;
        else if (s_axi_araddr[7:0] == `DCL_OFS_STATUS)
          s_axi_rdata <= {period, 9'h000, st != S_IDLE, is_last, pos};
        else if (s_axi_araddr[7:0] == `DCL_OFS_CONTROL)
          s_axi_rdata <= {31'h0000_0000, resp_en};
        else if (s_axi_araddr[7:6] == 2'h1)
          s_axi_rdata <= {16'h0000, regs[s_axi_araddr[5:2]]};
        else
          s_axi_rresp <= `DCL_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ---- test/dcl_checker.sv ----
// Assertion checker for the link node bus and line ports
`timescale 1ns/1ns
`include "dcl_defs.vh"
module dcl_checker (
  input wire        mclk,          // Clock
  input wire        reset_n,       // Reset
  input wire        up_out,        // Up drive
  input wire        up_oe_n,       // Up enable
  input wire [31:0] s_axi_awaddr,  // AW addr
  input wire        s_axi_awvalid, // AW valid
  input wire        s_axi_awready, // AW ready
  input wire        s_axi_wvalid,  // W valid
  input wire        s_axi_wready,  // W ready
  input wire [1:0]  s_axi_bresp,   // B resp
  input wire        s_axi_bvalid,  // B valid
  input wire        s_axi_bready,  // B ready
  input wire        s_axi_arvalid, // AR valid
  input wire        s_axi_arready, // AR ready
  input wire [31:0] s_axi_rdata,   // R data
  input wire        s_axi_rvalid,  // R valid
  input wire        s_axi_rready   // R ready
);
  // Joint write handshake, read address handshake
  wire aw_hs = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Answers come at fixed distance and stand until taken
  a_wr_answer: assert property (aw_hs |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  // Refusals while an answer is pending, and of unmapped writes
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_wr_unmapped: assert property (aw_hs && s_axi_awaddr[31:8] != 24'h0 |-> ##2 s_axi_bresp == `DCL_RESP_SLVERR)
    else $error("unmapped write not refused");
  // Line released only after a high level
  a_up_stop_high: assert property ($rose(up_oe_n) |-> $past(up_out))
    else $error("upstream released low");
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == `DCL_RESP_SLVERR);
  c_read: cover property (ar_hs);
  c_reply: cover property ($fell(up_oe_n));
endmodule
bind dcl_link dcl_checker chk_u (.mclk, .reset_n, .up_out, .up_oe_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// ---- test/dcl_host.sv ----
// Host model: frames bytes onto the upstream line and reads replies
`timescale 1ns/1ns
module dcl_host #(
  parameter BIT = 40 // Clocks per bit
) (
  input  wire mclk, // Clock
  input  wire line, // Resolved line
  output reg  tx    // Host drive, 1 releases
);
  initial tx = 1'b1;
  ////////////////////////////////////////
  // start low, LSB first, stop high
  task send_byte(input [7:0] b);
    integer   i;
    reg [9:0] f;
    begin
      f = {1'b1, b, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        tx <= f[i];
        repeat (BIT) @(posedge mclk);
      end
    end
  endtask
  // align on the start bit fall
  task recv_byte(output [7:0] b, output ok);
    integer i;
    begin
      ok = 1'b0;
      b = 8'h00;
      for (i = 0; i < 50 * BIT && line !== 1'b0; i = i + 1)
        @(posedge mclk);
      if (line === 1'b0) begin
        repeat (BIT / 2) @(posedge mclk);
        for (i = 0; i < 9; i = i + 1) begin
          repeat (BIT) @(posedge mclk);
          if (i < 8) b[i] = line;
        end
        ok = line;
      end
    end
  endtask
endmodule

// ---- test/dcl_link_bench.sv ----
// Self-checking bench for the link node
`timescale 1ns/1ns
`include "dcl_defs.vh"
module dcl_link_bench;
  reg         mclk, reset_n, awvalid, wvalid, bready, arvalid, rready, ok;
  reg  [31:0] awaddr, wdata, araddr, rd;
  reg  [7:0]  lo, hi;
  reg  [3:0]  wstrb;
  wire        awready, wready, bvalid, arready, rvalid, host_tx;
  wire        up_out, up_oe_n, dn_out, dn_oe_n;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     n_mismatch, checked;
  // Pulled-up lines; nothing hangs below this node
  wire up_line = host_tx & (up_oe_n | up_out);
  wire dn_line = dn_oe_n | dn_out;
  dcl_link #(.INIT_GAP_CYC(200), .INIT_TIMEOUT_CYC(5000), .OP_TIMEOUT_CYC(3000)) dut_u (
    .mclk(mclk), .reset_n(reset_n), .up_in(up_line), .up_out(up_out), .up_oe_n(up_oe_n),
    .dn_in(dn_line), .dn_out(dn_out), .dn_oe_n(dn_oe_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  dcl_host host_u (.mclk(mclk), .line(up_line), .tx(host_tx));
  ////////////////////////////////////////
  // Count a comparison and report a mismatch
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Bus write, each channel dropped when taken
  task axi_wr(input [31:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      forever begin
        @(posedge mclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) break;
      end
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
    end
  endtask
  // Bus read with masked compare
  task rd_chk(input [31:0] a, input [31:0] exp, input [1:0] er, input [31:0] m);
    begin
      @(posedge mclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      forever begin
        @(posedge mclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) break;
      end
      rd = rdata & m;
      rready <= 1'b0;
      chk("rdata", exp, rd);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
    end
  endtask
  // host opens with calibration, then n bytes lowest first
  task link(input integer n, input [39:0] s);
    integer i;
    begin
      host_u.send_byte(8'h55);
      for (i = 0; i < n; i = i + 1)
        host_u.send_byte(s[8*i +: 8]);
    end
  endtask
  // Two-byte reply, low byte first
  task reply(input [15:0] exp);
    begin
      host_u.recv_byte(lo, ok);
      host_u.recv_byte(hi, ok);
      chk("reply", {16'h0, exp}, {16'h0, hi, lo});
      // Let the node finish its stop bit and return to idle
      repeat (60) @(posedge mclk);
    end
  endtask
  // Verdict and end of run
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch = n_mismatch + 1;
    $display("[ERR] watchdog expected done seen hang");
    wrap_up;
  end
  // Main sequence
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hF;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    axi_wr(32'h4C, 32'hFFFFA5C3, `DCL_RESP_OKAY);
    rd_chk(32'h4C, 32'hA5C3, `DCL_RESP_OKAY, 32'hFFFFFFFF);
    wstrb <= 4'h1;
    axi_wr(32'h4C, 32'h0000_005A, `DCL_RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk(32'h4C, 32'hA55A, `DCL_RESP_OKAY, 32'hFFFFFFFF);
    axi_wr(32'h100, 32'h1, `DCL_RESP_SLVERR);
    axi_wr(32'h0, 32'h1, `DCL_RESP_SLVERR);
    rd_chk(32'h80, 32'h0, `DCL_RESP_SLVERR, 32'hFFFFFFFF);
    link(4, 40'h00_12_34_05_00);
    rd_chk(32'h54, 32'h1234, `DCL_RESP_OKAY, 32'hFFFF);
    link(4, 40'h00_99_99_05_18);
    repeat (3500) @(posedge mclk);
    rd_chk(32'h54, 32'h1234, `DCL_RESP_OKAY, 32'hFFFF);
    link(2, 40'h05_02);
    reply(16'h1234);
    link(4, 40'h00_BE_EF_06_11);
    rd_chk(32'h58, 32'hBEEF, `DCL_RESP_OKAY, 32'hFFFF);
    link(2, 40'h06_03);
    reply(16'hBEEF);
    link(1, 40'h57);
    host_u.recv_byte(lo, ok);
    chk("poll_quiet", 32'h0, {31'h0, ok});
    repeat (2000) @(posedge mclk);
    link(1, 40'h5D);
    rd_chk(32'h58, 32'h0, `DCL_RESP_OKAY, 32'hFFFF);
    link(2, 40'h08_95);
    host_u.recv_byte(lo, ok);
    chk("init", 32'h08, {24'h0, lo});
    repeat (6000) @(posedge mclk);
    rd_chk(32'h0, 32'h21, `DCL_RESP_OKAY, 32'h7F);
    link(2, 40'h00_1B);
    host_u.recv_byte(lo, ok);
    chk("overrun_quiet", 32'h0, {31'h0, ok});
    repeat (1500) @(posedge mclk);
    rd_chk(32'h0, 32'h21, `DCL_RESP_OKAY, 32'h7F);
    link(1, 40'h57);
    host_u.recv_byte(lo, ok);
    chk("poll", 32'h08, {24'h0, lo});
    wrap_up;
  end
endmodule
